// [design/dswp_frame_mem.sv]
// Purpose : Frame memory holding one 16-bit word per pixel
// Assumes : One write port and one read port on the system clock
// Notes   : Read data comes out of a register, one cycle after the address
`timescale 1ns/1ps
module dswp_frame_mem #(
   parameter int unsigned DEPTH = 153600,
   parameter int unsigned AW    = 18,
   parameter int unsigned DW    = 16
) (
   // Clock
   input  wire logic          clk_sys,
   // Write side
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [DW-1:0] wrData,
   // Read side
   input  wire logic [AW-1:0] rdAddr,
   output logic      [DW-1:0] rdData
);
   // Storage array, no reset so it maps onto block memory
   logic [DW-1:0] mem [DEPTH];

   // Registered write and read
   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule

// [design/dswp_pkg.sv]
// Purpose : Shared constants for the display serial write port
// Assumes : 320x480 panel, 16-bit 5-6-5 pixels, serial mode zero link
// Notes   : Command codes are kept small; only no-op, window, scan and write are decoded
package dswp_pkg;
   // ---------------------------------------------------------------
   // Geometry and memory
   // ---------------------------------------------------------------
   localparam int unsigned COLS        = 320;                 // Pixels per row
   localparam int unsigned ROWS        = 480;                 // Rows per frame
   localparam int unsigned PIX_BITS    = 16;                  // Pixel word width
   localparam int unsigned MEM_BYTES   = 345600;              // Capacity in bytes at 18 bits per pixel; unused, the frame memory holds 307200 bytes
   localparam int unsigned MEM_DEPTH   = COLS * ROWS;         // Pixel words held
   localparam int unsigned ADDR_W      = 18;                  // Pixel address width
   localparam int unsigned COORD_W     = 9;                   // Row or column coordinate width
   // ---------------------------------------------------------------
   // Pixel field layout (5-6-5)
   // ---------------------------------------------------------------
   localparam int unsigned RED_MSB     = 15;
   localparam int unsigned RED_LSB     = 11;
   localparam int unsigned GRN_MSB     = 10;
   localparam int unsigned GRN_LSB     = 5;
   localparam int unsigned BLU_MSB     = 4;
   localparam int unsigned BLU_LSB     = 0;
   // ---------------------------------------------------------------
   // Command codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CMD_NOP      = 8'h00;               // No operation
   localparam logic [7:0] CMD_COLSET   = 8'h2a;               // Column window start/end
   localparam logic [7:0] CMD_ROWSET   = 8'h2b;               // Row window start/end
   localparam logic [7:0] CMD_MEMWR    = 8'h2c;               // Start pixel stream
   localparam logic [7:0] CMD_SCAN     = 8'h36;               // Scan direction parameter
   // Scan parameter bits
   localparam int unsigned SCAN_COLDEC = 6;                   // Column decrements when set
   localparam int unsigned SCAN_ROWDEC = 7;                   // Row decrements when set
   localparam logic [7:0] SCAN_RST     = 8'h00;               // Scan setting after reset
   // ---------------------------------------------------------------
   // Link geometry
   // ---------------------------------------------------------------
   localparam int unsigned BYTE_BITS   = 8;                   // Bits per transfer unit
   localparam logic [2:0]  BIT_LAST    = 3'h7;                // Index of final bit in a byte
   // States of the command decoder
   typedef enum logic [1:0] {
      DSWP_IDLE  = 2'b00,
      DSWP_PARAM = 2'b01,
      DSWP_PIXLO = 2'b11,
      DSWP_STREAM= 2'b10
   } dswp_state_e;
endpackage

// [design/dswp_port.sv]
// Purpose : Serial write port of a colour display controller
// Assumes : Host is a mode-zero serial master; serial clock is the link clock
// Notes   : Bytes cross to clk_sys by a toggle handshake; one byte in flight at a time
`timescale 1ns/1ps
// What this block does
// - Serial traffic accepted only while select low
// - Select line low is command, high data
// - One bit captured per rising serial clock
// - Eight bits assemble into one byte
// - First bit received lands in top position
// - Active-low reset input resets the controller
// - Backlight output follows enable input level
// - Data sampled on first edge after idle
// - Link runs serial mode zero
// - Pixels are 16-bit 5-6-5 words
// - Address walks rows and columns per scan
// - Frame memory sized for 153600 16-bit words (307200 bytes)
module dswp_port #(
   parameter int unsigned COLS_P  = dswp_pkg::COLS,
   parameter int unsigned ROWS_P  = dswp_pkg::ROWS
) (
   // System side
   input  wire logic                      clk_sys,
   input  wire logic                      nrst,
   // Serial link pins
   input  wire logic                      sclk,
   input  wire logic                      selectN,
   input  wire logic                      sdata,
   input  wire logic                      cmd_data_select,
   input  wire logic                      panelRstN,
   input  wire logic                      backlight_enable,
   // Panel side
   output logic                           backlightOn,
   output logic                           pixWrStrobe,
   output logic [dswp_pkg::ADDR_W-1:0]    pixWrAddr,
   output logic [dswp_pkg::PIX_BITS-1:0]  pixWrData,
   output logic [7:0]                     lastCmd,
   output logic [7:0]                     scanMode,
   input  wire logic [dswp_pkg::ADDR_W-1:0] scanRdAddr,
   output logic [dswp_pkg::PIX_BITS-1:0]  scanRdData
);
   import dswp_pkg::*;

   // ---------------------------------------------------------------
   // Link domain: shifter on the serial clock
   // ---------------------------------------------------------------
   logic [6:0] shift_r, shift_nxt;         // Bits collected so far
   logic [2:0] bitCnt_r, bitCnt_nxt;       // Bit index within the byte
   logic [7:0] byteHold_r, byteHold_nxt;   // Completed byte held for crossing
   logic       kindHold_r, kindHold_nxt;   // Cmd/data level of the held byte
   logic       byteTgl_r, byteTgl_nxt;     // Flips once per completed byte

   // Next-state for the shifter
   always_comb begin
      shift_nxt    = shift_r;
      bitCnt_nxt   = bitCnt_r;
      byteHold_nxt = byteHold_r;
      kindHold_nxt = kindHold_r;
      byteTgl_nxt  = byteTgl_r;
      if (bitCnt_r == BIT_LAST) begin
         byteHold_nxt = {shift_r, sdata};
         kindHold_nxt = cmd_data_select;
         byteTgl_nxt  = ~byteTgl_r;
         bitCnt_nxt   = '0;
      end else begin
         shift_nxt  = {shift_r[5:0], sdata};
         bitCnt_nxt = bitCnt_r + 3'h1;
      end
   end

   // The bit counter is cleared by the select pin itself, since the serial
   // clock stops between frames and cannot be counted on to clear it.
   // select gates capture
   always_ff @(posedge sclk or posedge selectN) begin
      if (selectN) begin
         bitCnt_r <= '0;
         shift_r  <= '0;
      end else begin
         bitCnt_r <= bitCnt_nxt;
         shift_r  <= shift_nxt;
      end
   end

   // Held byte and toggle keep their value while deselected. The block reset
   // clears them with no serial clock, since the host parks that clock low;
   // without it the toggle would start unknown and no byte would ever cross.
   always_ff @(posedge sclk or negedge nrst) begin
      if (!nrst) begin
         byteHold_r <= '0;
         kindHold_r <= 1'b0;
         byteTgl_r  <= 1'b0;
      end else if (!selectN) begin
         byteHold_r <= byteHold_nxt;
         kindHold_r <= kindHold_nxt;
         byteTgl_r  <= byteTgl_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Crossing into clk_sys
   // ---------------------------------------------------------------
   logic tglS1_r, tglS2_r, tglS3_r;        // Toggle synchroniser and edge history
   logic rstS1_r, rstS2_r;                 // Panel reset synchroniser
   logic blS1_r, blS2_r;                   // Backlight synchroniser
   logic byteEvt;                          // One-cycle pulse per received byte
   logic ctlRst;                           // Controller reset, block or panel

   // Two flops per pin; the held byte is stable for a whole byte time
   // (eight serial clocks, far longer than three system clocks) when read.
   always_ff @(posedge clk_sys) begin
      tglS1_r <= byteTgl_r;
      tglS2_r <= tglS1_r;
      tglS3_r <= tglS2_r;
      rstS1_r <= panelRstN;
      rstS2_r <= rstS1_r;
      blS1_r  <= backlight_enable;
      blS2_r  <= blS1_r;
   end

   assign byteEvt = tglS2_r ^ tglS3_r;
   assign ctlRst  = !nrst || !rstS2_r;

   // ---------------------------------------------------------------
   // Command decoder and address walker
   // ---------------------------------------------------------------
   dswp_state_e        state_r, state_nxt;       // Decoder state
   logic [7:0]         cmd_r, cmd_nxt;           // Current command context
   logic [1:0]         parIdx_r, parIdx_nxt;     // Parameter byte index
   logic [7:0]         parHi_r, parHi_nxt;       // Upper byte of a 16-bit parameter
   logic [COORD_W-1:0] colS_r, colS_nxt, colE_r, colE_nxt;
   logic [COORD_W-1:0] rowS_r, rowS_nxt, rowE_r, rowE_nxt;
   logic [COORD_W-1:0] col_r, col_nxt, row_r, row_nxt;
   logic [7:0]         scan_r, scan_nxt;         // Scan direction setting
   logic [7:0]         pixHi_r, pixHi_nxt;       // Upper pixel byte
   logic               wr_r, wr_nxt;             // Memory write strobe
   logic [ADDR_W-1:0]  wa_r, wa_nxt;             // Memory write address
   logic [PIX_BITS-1:0] wd_r, wd_nxt;            // Memory write data
   logic               bl_r;                     // Backlight output register
   logic [7:0]         rxByte;
   logic               rxData;

   // Linear pixel address of a row and column
   function automatic logic [ADDR_W-1:0] pixAddr(input logic [COORD_W-1:0] r,
                                                 input logic [COORD_W-1:0] c);
      pixAddr = ADDR_W'(r * COLS_P + c);
   endfunction

   // Window start as seen from the scan direction
   function automatic logic [COORD_W-1:0] startOf(input logic dec,
                                                 input logic [COORD_W-1:0] s,
                                                 input logic [COORD_W-1:0] e);
      startOf = dec ? e : s;
   endfunction

   assign rxByte = byteHold_r;
   assign rxData = kindHold_r;

   // Next-state for decoder and walker
   always_comb begin
      state_nxt  = state_r;
      cmd_nxt    = cmd_r;
      parIdx_nxt = parIdx_r;
      parHi_nxt  = parHi_r;
      colS_nxt   = colS_r;
      colE_nxt   = colE_r;
      rowS_nxt   = rowS_r;
      rowE_nxt   = rowE_r;
      col_nxt    = col_r;
      row_nxt    = row_r;
      scan_nxt   = scan_r;
      pixHi_nxt  = pixHi_r;
      wr_nxt     = 1'b0;
      wa_nxt     = wa_r;
      wd_nxt     = wd_r;
      if (byteEvt) begin
         if (!rxData) begin
            cmd_nxt    = rxByte;
            parIdx_nxt = '0;
            if (rxByte == CMD_MEMWR) begin
               state_nxt = DSWP_STREAM;
               col_nxt   = startOf(scan_r[SCAN_COLDEC], colS_r, colE_r);
               row_nxt   = startOf(scan_r[SCAN_ROWDEC], rowS_r, rowE_r);
            end else if (rxByte == CMD_NOP) begin
               state_nxt = DSWP_IDLE;
            end else begin
               state_nxt = DSWP_PARAM;
            end
         end else begin
            case (state_r)
               DSWP_PARAM: begin
                  parIdx_nxt = parIdx_r + 2'h1;
                  if (cmd_r == CMD_SCAN) begin
                     scan_nxt = rxByte;
                  end else if (!parIdx_r[0]) begin
                     parHi_nxt = rxByte;
                  end else if (cmd_r == CMD_COLSET) begin
                     if (!parIdx_r[1]) colS_nxt = COORD_W'({parHi_r, rxByte});
                     else colE_nxt = COORD_W'({parHi_r, rxByte});
                  end else if (cmd_r == CMD_ROWSET) begin
                     if (!parIdx_r[1]) rowS_nxt = COORD_W'({parHi_r, rxByte});
                     else rowE_nxt = COORD_W'({parHi_r, rxByte});
                  end
               end
               DSWP_STREAM: begin
                  pixHi_nxt = rxByte;
                  state_nxt = DSWP_PIXLO;
               end
               DSWP_PIXLO: begin
                  wr_nxt    = 1'b1;
                  wa_nxt    = pixAddr(row_r, col_r);
                  wd_nxt    = {pixHi_r, rxByte};
                  state_nxt = DSWP_STREAM;
                  if (col_r == (scan_r[SCAN_COLDEC] ? colS_r : colE_r)) begin
                     col_nxt = startOf(scan_r[SCAN_COLDEC], colS_r, colE_r);
                     if (row_r == (scan_r[SCAN_ROWDEC] ? rowS_r : rowE_r))
                        row_nxt = startOf(scan_r[SCAN_ROWDEC], rowS_r, rowE_r);
                     else
                        row_nxt = scan_r[SCAN_ROWDEC] ? row_r - 1'b1 : row_r + 1'b1;
                  end else begin
                     col_nxt = scan_r[SCAN_COLDEC] ? col_r - 1'b1 : col_r + 1'b1;
                  end
               end
               default: begin
                  state_nxt = DSWP_IDLE;
               end
            endcase
         end
      end
   end

   // Registers of decoder and walker
   always_ff @(posedge clk_sys) begin
      if (ctlRst) begin
         state_r  <= DSWP_IDLE;
         cmd_r    <= CMD_NOP;
         parIdx_r <= '0;
         parHi_r  <= '0;
         colS_r   <= '0;
         colE_r   <= COORD_W'(COLS_P - 1);
         rowS_r   <= '0;
         rowE_r   <= COORD_W'(ROWS_P - 1);
         col_r    <= '0;
         row_r    <= '0;
         scan_r   <= SCAN_RST;
         pixHi_r  <= '0;
         wr_r     <= 1'b0;
         wa_r     <= '0;
         wd_r     <= '0;
      end else begin
         state_r  <= state_nxt;
         cmd_r    <= cmd_nxt;
         parIdx_r <= parIdx_nxt;
         parHi_r  <= parHi_nxt;
         colS_r   <= colS_nxt;
         colE_r   <= colE_nxt;
         rowS_r   <= rowS_nxt;
         rowE_r   <= rowE_nxt;
         col_r    <= col_nxt;
         row_r    <= row_nxt;
         scan_r   <= scan_nxt;
         pixHi_r  <= pixHi_nxt;
         wr_r     <= wr_nxt;
         wa_r     <= wa_nxt;
         wd_r     <= wd_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         bl_r <= 1'b0;
      end else begin
         bl_r <= blS2_r;
      end
   end

   // ---------------------------------------------------------------
   // Frame memory
   // ---------------------------------------------------------------
   // one word per pixel
   dswp_frame_mem #(
      .DEPTH (COLS_P * ROWS_P),
      .AW    (ADDR_W),
      .DW    (PIX_BITS)
   ) u_mem (
      .clk_sys (clk_sys),
      .wrEn    (wr_r),
      .wrAddr  (wa_r),
      .wrData  (wd_r),
      .rdAddr  (scanRdAddr),
      .rdData  (scanRdData)
   );

   // Outputs straight from flops
   assign backlightOn = bl_r;
   assign pixWrStrobe = wr_r;
   assign pixWrAddr   = wa_r;
   assign pixWrData   = wd_r;
   assign lastCmd     = cmd_r;
   assign scanMode    = scan_r;
endmodule

// [test/dswp_host_model.sv]
// Purpose : Behavioural serial master in front of the port
// Assumes : Mode zero link, 48 ns clock period
// Notes   : Clock parks low outside frames
`timescale 1ns/1ps
module dswp_host_model (
   // Link pins toward the device
   output logic sclk,
   output logic selectN,
   output logic sdata,
   output logic cmd_data_select
);
   localparam int HALF = 24; // Half of the 48 ns period
   // Idle: deselected, clock low
   initial begin
      sclk = 1'b0;
      selectN = 1'b1;
      sdata = 1'b1;
      cmd_data_select = 1'b0;
   end
   // Shift n bits, top bit first; 1.3 ns skew keeps edges off clk_sys
   // mode zero, steady select
   task automatic shift(input logic cd, input logic [7:0] b, input int n, input bit rel);
      #1.3;
      selectN = 1'b0;
      cmd_data_select = cd;
      for (int i = 7; i > 7 - n; i--) begin
         sdata = b[i];
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
      #HALF;
      if (rel) begin
         selectN = 1'b1;
         sdata = ~sdata; // Released line shows no stale bit
      end
   endtask
   // Clocking while deselected, only on bench command
   task automatic stray(input logic [7:0] b);
      for (int i = 0; i < 16; i++) begin
         sdata = b[i%8];
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
   endtask
endmodule

// [test/dswp_port_assertions.sv]
// Purpose : Port-level checks of the serial write port
// Assumes : All outputs sampled on clk_sys
// Notes   : Bound into every dswp_port instance
`timescale 1ns/1ps
module dswp_port_assertions #(
   parameter int unsigned COLS_P = 320,
   parameter int unsigned ROWS_P = 480
) (
   // System side
   input wire logic                            clk_sys,
   input wire logic                            nrst,
   // Pins seen at the port
   input wire logic                            selectN,
   input wire logic                            panelRstN,
   input wire logic                            backlight_enable,
   input wire logic [dswp_pkg::ADDR_W-1:0]     scanRdAddr,
   // Design outputs
   input wire logic                            backlightOn,
   input wire logic                            pixWrStrobe,
   input wire logic [dswp_pkg::ADDR_W-1:0]     pixWrAddr,
   input wire logic [dswp_pkg::PIX_BITS-1:0]   pixWrData,
   input wire logic [7:0]                      lastCmd,
   input wire logic [7:0]                      scanMode,
   input wire logic [dswp_pkg::PIX_BITS-1:0]   scanRdData
);
   import dswp_pkg::*;
   // ----------------------------------------
   // Clocking
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Deselected link: 8 cycles lets any byte in flight land first
   a_select_blocks: assert property ((selectN && panelRstN)[*8] |-> !pixWrStrobe && $stable(lastCmd))
      else $error("output moved while deselected");
   a_memwr_context: assert property (pixWrStrobe |-> lastCmd == CMD_MEMWR)
      else $error("pixel written outside write context");
   a_panel_reset: assert property (!panelRstN[*4] |=> lastCmd == CMD_NOP && scanMode == SCAN_RST)
      else $error("panel reset did not clear decoder");
   a_backlight_follow: assert property ($stable(backlight_enable)[*6] |-> backlightOn == backlight_enable)
      else $error("backlight does not follow enable");
   a_strobe_single: assert property (pixWrStrobe |=> !pixWrStrobe[*8])
      else $error("pixel strobe repeated too soon");
   a_hold_output: assert property (pixWrStrobe |=> ($stable(pixWrAddr) && $stable(pixWrData))[*8])
      else $error("pixel outputs not held");
   a_addr_range: assert property (pixWrStrobe |-> pixWrAddr < COLS_P * ROWS_P)
      else $error("pixel address beyond frame");
   a_read_back: assert property (pixWrStrobe ##4 (scanRdAddr == pixWrAddr)[*2] |-> scanRdData == pixWrData)
      else $error("frame memory read back differs");
   // Main scenarios reached
   c_pixel: cover property (pixWrStrobe);
   c_panel: cover property (!panelRstN ##1 panelRstN);
   c_select: cover property (selectN ##1 !selectN);
endmodule
bind dswp_port dswp_port_assertions #(.COLS_P(COLS_P), .ROWS_P(ROWS_P)) dswp_port_assertions_inst (
   .clk_sys(clk_sys), .nrst(nrst), .selectN(selectN), .panelRstN(panelRstN),
   .backlight_enable(backlight_enable), .scanRdAddr(scanRdAddr), .backlightOn(backlightOn),
   .pixWrStrobe(pixWrStrobe), .pixWrAddr(pixWrAddr), .pixWrData(pixWrData),
   .lastCmd(lastCmd), .scanMode(scanMode), .scanRdData(scanRdData));

// [test/tb_dswp_port.sv]
// Purpose : Self-checking bench of the serial write port
// Assumes : Reference model predicts every pixel strobe
// Notes   : Scan direction at increment for the first streams, then both reversed
`timescale 1ns/1ps
module tb_dswp_port;
   import dswp_pkg::*;
   // Bench-driven inputs
   logic                clk_sys = 1'b0;
   logic                nrst;
   logic                panelRstN = 1'b1;
   logic                backlight_enable = 1'b0;
   logic [ADDR_W-1:0]   scanRdAddr = '0;
   // Link and outputs
   wire                 sclk, selectN, sdata, cmdSel;
   logic                backlightOn, pixWrStrobe;
   logic [ADDR_W-1:0]   pixWrAddr;
   logic [PIX_BITS-1:0] pixWrData, scanRdData;
   logic [7:0]          lastCmd, scanMode, r;
   int                  failures = 0, n_tests = 0, cyc = 0;
   integer              seed = 32'h5d27;
   // Reference model: window, cursor, expected strobes, memory
   int                  c0, c1, r0, r1, col, row;
   int                  cdec = 0, rdec = 0;       // Scan direction: 1 walks downward
   int                  addrQ[$], dataQ[$], mem[int];

   always #2 clk_sys = ~clk_sys;

   dswp_port #(.COLS_P(COLS), .ROWS_P(ROWS)) dswp_port_inst (
      .clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .selectN(selectN), .sdata(sdata),
      .cmd_data_select(cmdSel), .panelRstN(panelRstN), .backlight_enable(backlight_enable),
      .backlightOn(backlightOn), .pixWrStrobe(pixWrStrobe), .pixWrAddr(pixWrAddr),
      .pixWrData(pixWrData), .lastCmd(lastCmd), .scanMode(scanMode),
      .scanRdAddr(scanRdAddr), .scanRdData(scanRdData));
   dswp_host_model dswp_host_model_inst (
      .sclk(sclk), .selectN(selectN), .sdata(sdata), .cmd_data_select(cmdSel));

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Hang guard: whole run needs about 4800 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end
   // Each strobe must match the oldest predicted pixel
   always @(posedge clk_sys) begin
      if (pixWrStrobe === 1'b1) begin
         if (addrQ.size() == 0) check("unexpected strobe", 0, 1);
         else begin
            scanRdAddr <= ADDR_W'(addrQ[0]);
            check("pixWrAddr", addrQ.pop_front(), pixWrAddr);
            check("pixWrData", dataQ.pop_front(), pixWrData);
         end
      end
   end
   task automatic send(input logic cd, input logic [7:0] b);
      dswp_host_model_inst.shift(cd, b, 8, 1'b1);
   endtask
   // Predict, then send upper byte first
   task automatic pixel(input logic [15:0] p);
      addrQ.push_back(row * COLS + col);
      dataQ.push_back(p);
      mem[row*COLS+col] = p;
      // Step along the scan direction, wrapping to the window start
      if (col == (cdec ? c0 : c1)) begin
         col = cdec ? c1 : c0;
         if (row == (rdec ? r0 : r1)) row = rdec ? r1 : r0;
         else row = rdec ? row - 1 : row + 1;
      end
      else col = cdec ? col - 1 : col + 1;
      dswp_host_model_inst.shift(1'b1, p[15:8], 8, 1'b0);
      send(1'b1, p[7:0]);
   endtask
   // Wait for predicted strobes, then for strays
   task automatic drain(input string name);
      for (int k = 0; k < 40 && addrQ.size() != 0; k++) @(posedge clk_sys);
      repeat (12) @(posedge clk_sys);
      check("pending pixels", 0, addrQ.size());
      $display("Test %s done", name);
   endtask

   initial begin
      // Falling edge at time zero also clears the link-side toggle
      nrst <= 1'b0;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("lastCmd", CMD_NOP, lastCmd);
      check("scanMode", SCAN_RST, scanMode);
      for (int k = 0; k < 4; k++) begin
         backlight_enable <= k[0] ^ 1'($random(seed));
         repeat (8) @(posedge clk_sys);
         check("backlightOn", backlight_enable, backlightOn);
      end
      // Scan parameter, then panel reset clears it
      r = 8'($random(seed)) | 8'h01;
      send(1'b0, CMD_SCAN);
      send(1'b1, r);
      drain("scan");
      check("scanMode", r, scanMode);
      panelRstN <= 1'b0;
      repeat (6) @(posedge clk_sys);
      panelRstN <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("scanMode", SCAN_RST, scanMode);
      check("backlightOn", backlight_enable, backlightOn);
      // Window 2..4 x 5..6, select dropped after every byte but the upper byte of each pixel
      c0 = 2; c1 = 4; r0 = 5; r1 = 6;
      mem.delete();
      for (int k = 0; k < 4; k++) begin
         if (k % 2 == 0) send(1'b0, (k == 0) ? CMD_COLSET : CMD_ROWSET);
         send(1'b1, 8'(((k % 2 == 0) ? ((k == 0) ? c0 : r0) : ((k == 1) ? c1 : r1)) >> 8));
         send(1'b1, 8'((k % 2 == 0) ? ((k == 0) ? c0 : r0) : ((k == 1) ? c1 : r1)));
      end
      send(1'b0, CMD_MEMWR);
      col = c0;
      row = r0;
      for (int k = 0; k < 7; k++) pixel(16'($random(seed)));
      drain("stream");
      // Partial byte dropped, pairing kept
      dswp_host_model_inst.shift(1'b1, 8'($random(seed)), 4, 1'b1);
      pixel(16'($random(seed)));
      drain("partial");
      dswp_host_model_inst.stray(8'($random(seed)));
      drain("stray");
      check("lastCmd", CMD_MEMWR, lastCmd);
      scanRdAddr <= ADDR_W'(r0 * COLS + c0);
      repeat (3) @(posedge clk_sys);
      check("scanRdData", mem[r0*COLS+c0], scanRdData);
      // Both directions reversed: the walk starts at the window end
      r = 8'((1 << SCAN_COLDEC) | (1 << SCAN_ROWDEC));
      send(1'b0, CMD_SCAN);
      send(1'b1, r);
      send(1'b0, CMD_MEMWR);
      cdec = 1;
      rdec = 1;
      col = c1;
      row = r1;
      for (int k = 0; k < 4; k++) pixel(16'($random(seed)));
      drain("reverse");
      check("scanMode", r, scanMode);
      // Data after a no-op command writes nothing
      send(1'b0, CMD_NOP);
      send(1'b1, 8'($random(seed)));
      send(1'b1, 8'($random(seed)));
      drain("nop");
      check("lastCmd", CMD_NOP, lastCmd);
      end_of_test();
   end
endmodule
